// file: lnbr_pkg.sv
// Shared constants for the supply regulator control register bank
package lnbr_pkg;

  // Register indices
  localparam logic [7:0] REG_OUTPUT_SETUP = 8'h00;
  localparam logic [7:0] REG_PROTECT_TONE = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;

  // Reset values
  localparam logic [7:0] OUTPUT_SETUP_RST = 8'h08;
  localparam logic [7:0] PROTECT_TONE_RST = 8'h09;

  // Output setup control fields
  localparam int OS_BUS_CONTROL = 7;
  localparam int OS_FORCED_SW = 6;
  localparam int OS_VCODE_HI = 4;
  localparam int OS_VCODE_LO = 1;
  localparam int OS_WIDE_TONE = 0;

  // Protection and tone control fields
  localparam int PT_TONE_LEVEL = 7;
  localparam int PT_HICCUP_LONG = 6;
  localparam int PT_CURRENT_HIGH = 5;
  localparam int PT_RATE_SELECT = 4;
  localparam int PT_SUPPLY_EN = 3;
  localparam int PT_DETECT_BEH = 2;
  localparam int PT_BYPASS_AUTO = 1;
  localparam int PT_BYPASS_TX = 0;

  // Status fields
  localparam int ST_TONE_GOOD = 6;
  localparam int ST_LDO_ON = 5;
  localparam int ST_HOT = 4;
  localparam int ST_THERMAL = 3;
  localparam int ST_OVERCURRENT = 2;
  localparam int ST_CABLE_GOOD = 1;
  localparam int ST_VOUT_GOOD = 0;

  // Strap code to 7-bit target address
  localparam logic [6:0] BUS_ADDR_0 = 7'h08;
  localparam logic [6:0] BUS_ADDR_1 = 7'h09;
  localparam logic [6:0] BUS_ADDR_2 = 7'h10;
  localparam logic [6:0] BUS_ADDR_3 = 7'h11;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [9:0] {
    ST_IDLE      = 10'h001,
    ST_ADDR      = 10'h002,
    ST_ADDR_ACK  = 10'h004,
    ST_WREG      = 10'h008,
    ST_WREG_ACK  = 10'h010,
    ST_WDATA     = 10'h020,
    ST_WDATA_ACK = 10'h040,
    ST_RDATA     = 10'h080,
    ST_RACK      = 10'h100,
    ST_RLOAD     = 10'h200
  } lnbr_state_t;

endpackage

// file: lnbr_regs.sv
// Two-wire target register bank for the supply regulator controls
`timescale 1ns/1ps
// Operation
// - Device acknowledges each byte by holding data low for one clock high.
// - Written value lands at falling clock edge of the data byte's last bit.
// - No register updates accepted while the enable pin is low.
// - Register 0 bit 6 picks power-save or forced switching.
// - Register 0 bits 4..1 hold the output voltage code.
// - Register 0 bit 0 enables the wide tone input and output.
// - Register 0 resets to 0x08.
// - Register 1 resets to 0x09.
// - Register 1 bit 7 picks tone amplitude.
// - Register 1 bit 6 picks short or long hiccup timing.
// - Register 1 bit 5 scales the boost peak current limit.
// - Register 1 bit 4 picks boost switching rate.
// - Register 1 bit 3 enables the regulated supply output.
// - Behaviour bit 0 drives detect output low while tone present.
// - Bypass FET follows transmit bit, or tone activity when auto set.
// - Transmit bit 1 turns bypass FET on, 0 turns it off.
// - Status flags follow conditions live, clearing without bus access.
// - Thermal or overcurrent latches fault low until status is read.
// - Status register 2 holds thermal, overcurrent and good indications.
// - Single strap-chosen 7-bit address; no 10-bit, no general call.
module lnbr_regs
  import lnbr_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Straps and pins
  input wire logic [1:0] addr_strap_in,
  input wire logic enable_pin_in,
  // Analog condition inputs
  input wire logic thermal_shutdown_flag_in,
  input wire logic overcurrent_flag_in,
  input wire logic hot_die_in,
  input wire logic ldo_on_in,
  input wire logic cable_good_in,
  input wire logic vout_good_in,
  input wire logic tone_detect_good_in,
  input wire logic tone_present_in,
  input wire logic tone_tx_active_in,
  // Output setup controls
  output logic output_bus_control_out,
  output logic forced_switching_select_out,
  output logic [3:0] output_voltage_code_out,
  output logic wide_tone_input_select_out,
  // Protection and tone controls
  output logic tone_level_select_out,
  output logic hiccup_long_select_out,
  output logic current_scale_high_out,
  output logic switching_rate_select_out,
  output logic regulated_supply_output_en_out,
  output logic bypass_gate_drive_out,
  output logic detect_out_n_out,
  output logic fault_n_out
);

  typedef struct packed {
    lnbr_state_t state;
    logic scl_p;
    logic sda_p;
    logic [7:0] shift;
    logic [3:0] cnt;
    logic rw;
    logic [7:0] ptr;
    logic [7:0] tx;
    logic [7:0] setup;
    logic [7:0] prot;
    logic sda_lvl;
    logic sda_oe;
    logic fault_n;
    logic strap_done;
    logic [6:0] dev_addr;
    logic gate;
    logic det_n;
  } lnbr_regs_t;

  lnbr_regs_t q;
  lnbr_regs_t n;

  localparam lnbr_regs_t RESET_STATE = '{
    state: ST_IDLE,
    scl_p: 1'b1,
    sda_p: 1'b1,
    shift: 8'h00,
    cnt: 4'h0,
    rw: 1'b0,
    ptr: 8'h00,
    tx: 8'h00,
    setup: OUTPUT_SETUP_RST,
    prot: PROTECT_TONE_RST,
    sda_lvl: 1'b0,
    sda_oe: 1'b0,
    fault_n: 1'b1,
    strap_done: 1'b0,
    dev_addr: BUS_ADDR_0,
    gate: 1'b1,
    det_n: 1'b1
  };

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic status_read;
  logic [7:0] status_byte;
  logic [7:0] read_byte;

  // Field map sanity: a bad package edit stops elaboration instead of misplacing bits
  if (BITS_PER_BYTE != $bits(read_byte)) begin : g_byte_width
    $error("Bit counter limit must equal the register width");
  end
  if (OS_VCODE_HI - OS_VCODE_LO + 1 != $bits(output_voltage_code_out)) begin : g_vcode_width
    $error("Voltage code field must match its port width");
  end
  if (OS_BUS_CONTROL >= BITS_PER_BYTE || OS_FORCED_SW >= BITS_PER_BYTE
      || OS_VCODE_HI >= BITS_PER_BYTE || OS_WIDE_TONE >= BITS_PER_BYTE) begin : g_setup_fields
    $error("Output setup field lies outside the register");
  end
  if (OS_VCODE_LO <= OS_WIDE_TONE || OS_VCODE_HI >= OS_FORCED_SW
      || OS_FORCED_SW == OS_BUS_CONTROL) begin : g_setup_overlap
    $error("Output setup fields overlap");
  end
  if (PT_TONE_LEVEL >= BITS_PER_BYTE || PT_HICCUP_LONG >= BITS_PER_BYTE
      || PT_CURRENT_HIGH >= BITS_PER_BYTE || PT_RATE_SELECT >= BITS_PER_BYTE
      || PT_SUPPLY_EN >= BITS_PER_BYTE || PT_DETECT_BEH >= BITS_PER_BYTE
      || PT_BYPASS_AUTO >= BITS_PER_BYTE || PT_BYPASS_TX >= BITS_PER_BYTE) begin : g_prot
    $error("Protection and tone field lies outside the register");
  end
  if (ST_TONE_GOOD >= BITS_PER_BYTE || ST_LDO_ON >= BITS_PER_BYTE
      || ST_HOT >= BITS_PER_BYTE || ST_THERMAL >= BITS_PER_BYTE
      || ST_OVERCURRENT >= BITS_PER_BYTE || ST_CABLE_GOOD >= BITS_PER_BYTE
      || ST_VOUT_GOOD >= BITS_PER_BYTE) begin : g_status_fields
    $error("Status field lies outside the register");
  end
  if (REG_OUTPUT_SETUP == REG_PROTECT_TONE || REG_OUTPUT_SETUP == REG_STATUS
      || REG_PROTECT_TONE == REG_STATUS) begin : g_reg_index
    $error("Register indices must differ");
  end
  // A zero address would let the general call match
  if (BUS_ADDR_0 == '0 || BUS_ADDR_1 == '0 || BUS_ADDR_2 == '0
      || BUS_ADDR_3 == '0) begin : g_addr_zero
    $error("Strap address must not be the general call address");
  end
  if (BUS_ADDR_0 == BUS_ADDR_1 || BUS_ADDR_0 == BUS_ADDR_2 || BUS_ADDR_0 == BUS_ADDR_3
      || BUS_ADDR_1 == BUS_ADDR_2 || BUS_ADDR_1 == BUS_ADDR_3
      || BUS_ADDR_2 == BUS_ADDR_3) begin : g_addr_unique
    $error("Strap addresses must differ");
  end
  // Reserved detect code must never come out of reset
  if (PROTECT_TONE_RST[PT_DETECT_BEH]) begin : g_detect_rst
    $error("Detect behaviour bit must reset to zero");
  end

  always_comb begin
    scl_rise = scl_in & ~q.scl_p;
    scl_fall = ~scl_in & q.scl_p;
    bus_start = scl_in & q.scl_p & q.sda_p & ~sda_in;
    bus_stop = scl_in & q.scl_p & ~q.sda_p & sda_in;
    // Live condition flags, nothing latched here
    status_byte = 8'h00;
    status_byte[ST_TONE_GOOD] = tone_detect_good_in;
    status_byte[ST_LDO_ON] = ldo_on_in;
    status_byte[ST_HOT] = hot_die_in;
    status_byte[ST_THERMAL] = thermal_shutdown_flag_in;
    status_byte[ST_OVERCURRENT] = overcurrent_flag_in;
    status_byte[ST_CABLE_GOOD] = cable_good_in;
    status_byte[ST_VOUT_GOOD] = vout_good_in;
    unique case (q.ptr)
      REG_OUTPUT_SETUP: read_byte = q.setup;
      REG_PROTECT_TONE: read_byte = q.prot;
      REG_STATUS: read_byte = status_byte;
      default: read_byte = 8'h00;
    endcase
  end

  always_comb begin
    n = q;
    status_read = 1'b0;
    n.scl_p = scl_in;
    n.sda_p = sda_in;
    n.sda_lvl = 1'b0;
    // Strap caught once after reset release
    if (!q.strap_done) begin
      n.strap_done = 1'b1;
      unique case (addr_strap_in)
        2'h0: n.dev_addr = BUS_ADDR_0;
        2'h1: n.dev_addr = BUS_ADDR_1;
        2'h2: n.dev_addr = BUS_ADDR_2;
        2'h3: n.dev_addr = BUS_ADDR_3;
      endcase
    end
    if (bus_start) begin
      n.state = ST_ADDR;
      n.cnt = 4'h0;
      n.sda_oe = 1'b0;
    end else if (bus_stop) begin
      n.state = ST_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      unique case (q.state)
        ST_IDLE: begin
          n.sda_oe = 1'b0;
        end
        ST_ADDR, ST_WREG, ST_WDATA: begin
          if (scl_rise) begin
            n.shift = {q.shift[6:0], sda_in};
            n.cnt = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == BITS_PER_BYTE) begin
            n.cnt = 4'h0;
            n.sda_oe = 1'b1;
            if (q.state == ST_ADDR) begin
              // Ten-bit headers and general call never match
              if (q.shift[7:1] == q.dev_addr) begin
                n.rw = q.shift[0];
                n.state = ST_ADDR_ACK;
              end else begin
                n.sda_oe = 1'b0;
                n.state = ST_IDLE;
              end
            end else if (q.state == ST_WREG) begin
              n.ptr = q.shift;
              n.state = ST_WREG_ACK;
            end else begin
              // Byte lands at the last bit's falling edge
              if (enable_pin_in) begin
                if (q.ptr == REG_OUTPUT_SETUP) begin
                  n.setup = q.shift;
                end else if (q.ptr == REG_PROTECT_TONE) begin
                  n.prot = q.shift;
                end
              end
              n.state = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_RLOAD: begin
          if (scl_fall) begin
            n.cnt = 4'h0;
            if (q.state == ST_RLOAD || q.rw) begin
              n.tx = read_byte;
              n.sda_oe = ~read_byte[7];
              status_read = (q.ptr == REG_STATUS);
              n.state = ST_RDATA;
            end else begin
              n.sda_oe = 1'b0;
              n.state = ST_WREG;
            end
          end
        end
        ST_WREG_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            n.cnt = 4'h0;
            n.state = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            n.tx = {q.tx[6:0], 1'b0};
            n.cnt = q.cnt + 4'h1;
          end else if (scl_fall) begin
            if (q.cnt == BITS_PER_BYTE) begin
              n.sda_oe = 1'b0;
              n.state = ST_RACK;
            end else begin
              n.sda_oe = ~q.tx[7];
            end
          end
        end
        ST_RACK: begin
          // Controller nack ends the read; ack repeats the register
          if (scl_rise) begin
            n.state = sda_in ? ST_IDLE : ST_RLOAD;
          end
        end
        default: begin
          n.state = ST_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end
    // New fault beats a simultaneous status read
    n.fault_n = ~((~q.fault_n & ~status_read)
                  | thermal_shutdown_flag_in | overcurrent_flag_in);
    if (q.prot[PT_BYPASS_AUTO]) begin
      n.gate = tone_tx_active_in;
    end else begin
      n.gate = q.prot[PT_BYPASS_TX];
    end
    // Reserved behaviour code leaves the detect output idle
    n.det_n = ~(tone_present_in & ~q.prot[PT_DETECT_BEH]);
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= RESET_STATE;
    end else begin
      q <= n;
    end
  end

  assign sda_out = q.sda_lvl;
  assign sda_oe_out = q.sda_oe;
  assign output_bus_control_out = q.setup[OS_BUS_CONTROL];
  assign forced_switching_select_out = q.setup[OS_FORCED_SW];
  assign output_voltage_code_out = q.setup[OS_VCODE_HI:OS_VCODE_LO];
  assign wide_tone_input_select_out = q.setup[OS_WIDE_TONE];
  assign tone_level_select_out = q.prot[PT_TONE_LEVEL];
  assign hiccup_long_select_out = q.prot[PT_HICCUP_LONG];
  assign current_scale_high_out = q.prot[PT_CURRENT_HIGH];
  assign switching_rate_select_out = q.prot[PT_RATE_SELECT];
  assign regulated_supply_output_en_out = q.prot[PT_SUPPLY_EN];
  assign bypass_gate_drive_out = q.gate;
  assign detect_out_n_out = q.det_n;
  assign fault_n_out = q.fault_n;

endmodule // lnbr_regs

// file: lnbr_regs_chk.sv
// Port-level concurrent checks for the register bank
`timescale 1ns/1ps
module lnbr_regs_chk (
  // Clock, reset and bus
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic enable_pin_in,
  // Conditions
  input wire logic thermal_shutdown_flag_in,
  input wire logic overcurrent_flag_in,
  input wire logic tone_present_in,
  // Controls
  input wire logic [3:0] output_voltage_code_out,
  input wire logic output_bus_control_out,
  input wire logic forced_switching_select_out,
  input wire logic wide_tone_input_select_out,
  input wire logic tone_level_select_out,
  input wire logic hiccup_long_select_out,
  input wire logic current_scale_high_out,
  input wire logic switching_rate_select_out,
  input wire logic regulated_supply_output_en_out,
  input wire logic detect_out_n_out,
  input wire logic fault_n_out
);
  logic [11:0] cfg;
  assign cfg = {output_bus_control_out, forced_switching_select_out, output_voltage_code_out,
    wide_tone_input_select_out, tone_level_select_out, hiccup_long_select_out,
    current_scale_high_out, switching_rate_select_out, regulated_supply_output_en_out};
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  property p_ack_hold; sda_oe_out && scl_in |=> sda_oe_out || !scl_in; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("pull released during clock high");
  property p_ack_setup; $rose(sda_oe_out) |-> !scl_in; endproperty
  a_ack_setup: assert property (p_ack_setup) else $error("pull began during clock high");
  property p_open_drain; !sda_out; endproperty
  a_open_drain: assert property (p_open_drain) else $error("data driven high");
  property p_locked; !enable_pin_in |=> $stable(cfg); endproperty
  a_locked: assert property (p_locked) else $error("control changed while disabled");
  property p_update_low; $changed(cfg) |-> !scl_in && !$past(scl_in); endproperty
  a_update_low: assert property (p_update_low) else $error("update off clock low");
  property p_fault_set; thermal_shutdown_flag_in || overcurrent_flag_in |=> !fault_n_out;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not latched");
  property p_fault_free;
    $rose(fault_n_out) |-> !scl_in && !$past(thermal_shutdown_flag_in)
      && !$past(overcurrent_flag_in);
  endproperty
  a_fault_free: assert property (p_fault_free) else $error("fault released early");
  property p_detect; 1'b1 |=> detect_out_n_out == !$past(tone_present_in); endproperty
  a_detect: assert property (p_detect) else $error("detect output wrong");
endmodule // lnbr_regs_chk

bind lnbr_regs lnbr_regs_chk u_chk (
  .mclk_in(mclk_in), .rst_in(rst_in), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .enable_pin_in(enable_pin_in),
  .thermal_shutdown_flag_in(thermal_shutdown_flag_in),
  .overcurrent_flag_in(overcurrent_flag_in), .tone_present_in(tone_present_in),
  .output_voltage_code_out(output_voltage_code_out),
  .output_bus_control_out(output_bus_control_out),
  .forced_switching_select_out(forced_switching_select_out),
  .wide_tone_input_select_out(wide_tone_input_select_out),
  .tone_level_select_out(tone_level_select_out),
  .hiccup_long_select_out(hiccup_long_select_out),
  .current_scale_high_out(current_scale_high_out),
  .switching_rate_select_out(switching_rate_select_out),
  .regulated_supply_output_en_out(regulated_supply_output_en_out),
  .detect_out_n_out(detect_out_n_out), .fault_n_out(fault_n_out)
);

// file: lnbr_host.sv
// Bus controller model issuing register writes and reads
`timescale 1ns/1ps
module lnbr_host (
  // Clock and bus lines
  input wire logic mclk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_pull_out
);
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  task automatic hold();
    repeat (4) @(posedge mclk_in);
  endtask
  // Data moves well clear of clock edges so no false start or stop
  task automatic bit_cell(input logic b, output logic r);
    hold();
    sda_pull_out <= ~b;
    hold();
    scl_out <= 1'b1;
    hold();
    r = sda_in;
    scl_out <= 1'b0;
  endtask
  task automatic start_cond();
    hold();
    sda_pull_out <= 1'b0;
    hold();
    scl_out <= 1'b1;
    hold();
    sda_pull_out <= 1'b1;
    hold();
    scl_out <= 1'b0;
  endtask
  task automatic stop_cond();
    hold();
    sda_pull_out <= 1'b1;
    hold();
    scl_out <= 1'b1;
    hold();
    sda_pull_out <= 1'b0;
    hold();
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cell(b[i], r);
    bit_cell(1'b1, r);
    ack = ~r;
  endtask
  task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                           output logic ok);
    logic k0, k1, k2;
    start_cond();
    put_byte({a, 1'b0}, k0);
    put_byte(p, k1);
    put_byte(d, k2);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask
  // Single byte then not-acknowledge; status reads also free the fault
  task automatic read_reg(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d);
    logic k, r;
    start_cond();
    put_byte({a, 1'b0}, k);
    put_byte(p, k);
    start_cond();
    put_byte({a, 1'b1}, k);
    for (int i = 7; i >= 0; i--) bit_cell(1'b1, d[i]);
    bit_cell(1'b1, r);
    stop_cond();
  endtask
endmodule // lnbr_host

// file: lnbr_regs_tb.sv
// Self-checking bench for the supply regulator register bank
`timescale 1ns/1ps
module lnbr_regs_tb;
  import lnbr_pkg::*;
  logic mclk_in, rst_in, scl, sda, pull, sda_o, oe, en, thermal_shutdown_flag, overcurrent_flag, hot, ldo, cab, vg, tg;
  logic tone_in, tone_tx, bus_ctl, forced, wide, lvl, hic, cur, rate, sup, gate, det_n, flt_n;
  logic [3:0] vcode;
  logic [7:0] rd;
  logic ok;
  logic [1:0] strap;
  logic [6:0] tgt;
  logic [7:0] tbl [4] = '{8'hd8, 8'ha1, 8'h28, 8'h09};
  int n_fail, total_checks;
  assign sda = ~(pull | oe);
  lnbr_regs u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_out(oe), .addr_strap_in(strap), .enable_pin_in(en),
    .thermal_shutdown_flag_in(thermal_shutdown_flag), .overcurrent_flag_in(overcurrent_flag), .hot_die_in(hot),
    .ldo_on_in(ldo), .cable_good_in(cab), .vout_good_in(vg), .tone_detect_good_in(tg),
    .tone_present_in(tone_in), .tone_tx_active_in(tone_tx), .output_bus_control_out(bus_ctl),
    .forced_switching_select_out(forced), .output_voltage_code_out(vcode),
    .wide_tone_input_select_out(wide), .tone_level_select_out(lvl),
    .hiccup_long_select_out(hic), .current_scale_high_out(cur),
    .switching_rate_select_out(rate), .regulated_supply_output_en_out(sup),
    .bypass_gate_drive_out(gate), .detect_out_n_out(det_n), .fault_n_out(flt_n));
  lnbr_host u_host (.mclk_in(mclk_in), .sda_in(sda), .scl_out(scl), .sda_pull_out(pull));
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    u_host.write_reg(tgt, p, d, ok);
    chk({7'h00, ok}, 8'h01);
  endtask
  task automatic rd_chk(input logic [7:0] p, input logic [7:0] exp);
    u_host.read_reg(tgt, p, rd);
    chk(rd, exp);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic complete_run();
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #500000;
    n_fail++;
    complete_run();
  end
  initial begin
    rst_in = 1'b1;
    en = 1'b1;
    strap = 2'h2;
    tgt = BUS_ADDR_2;
    {thermal_shutdown_flag, overcurrent_flag, hot, ldo, cab, vg, tg, tone_in, tone_tx} = '0;
    cycles(16);
    rst_in <= 1'b0;
    cycles(4);
    chk({bus_ctl, forced, 1'b0, vcode, wide}, 8'h08);
    chk({lvl, hic, cur, rate, sup, 2'b00, gate}, 8'h09);
    rd_chk(8'h00, 8'h08);
    rd_chk(8'h01, 8'h09);
    for (int v = 0; v < 16; v++) begin
      wr(8'h00, {1'b1, v[1], 1'b0, v[3:0], v[0]});
      chk({bus_ctl, forced, 1'b0, vcode, wide}, {1'b1, v[1], 1'b0, v[3:0], v[0]});
    end
    rd_chk(8'h00, 8'hdf);
    for (int i = 0; i < 4; i++) begin
      wr(8'h01, tbl[i]);
      chk({lvl, hic, cur, rate, sup, 2'b00, gate}, {tbl[i][7:3], 2'b00, tbl[i][0]});
      rd_chk(8'h01, tbl[i]);
    end
    wr(8'h01, 8'h0a);
    for (int t = 0; t < 2; t++) begin
      tone_tx <= t[0];
      cycles(3);
      chk({7'h00, gate}, {7'h00, t[0]});
    end
    en <= 1'b0;
    wr(8'h00, 8'h02);
    en <= 1'b1;
    rd_chk(8'h00, 8'hdf);
    u_host.write_reg(BUS_ADDR_0, 8'h00, 8'h02, ok);
    chk({7'h00, ok}, 8'h00);
    rd_chk(8'h00, 8'hdf);
    rd_chk(8'h05, 8'h00);
    wr(8'h02, 8'hff);
    rd_chk(8'h01, 8'h0a);
    {tg, ldo, hot, cab, vg} <= 5'b10101;
    rd_chk(8'h02, 8'h51);
    {tg, ldo, hot, cab, vg} <= 5'b01010;
    rd_chk(8'h02, 8'h22);
    for (int f = 0; f < 2; f++) begin
      {thermal_shutdown_flag, overcurrent_flag} <= f[0] ? 2'b01 : 2'b10;
      cycles(2);
      chk({7'h00, flt_n}, 8'h00);
      rd_chk(8'h02, f[0] ? 8'h26 : 8'h2a);
      chk({7'h00, flt_n}, 8'h00);
      {thermal_shutdown_flag, overcurrent_flag} <= 2'b00;
      cycles(4);
      chk({7'h00, flt_n}, 8'h00);
      rd_chk(8'h02, 8'h22);
      chk({7'h00, flt_n}, 8'h01);
    end
    tone_in <= 1'b1;
    cycles(2);
    chk({7'h00, det_n}, 8'h00);
    tone_in <= 1'b0;
    cycles(2);
    chk({7'h00, det_n}, 8'h01);
    // New strap takes effect only through a reset
    strap <= 2'h0;
    rst_in <= 1'b1;
    cycles(2);
    rst_in <= 1'b0;
    cycles(3);
    tgt = BUS_ADDR_0;
    chk({lvl, hic, cur, rate, sup, 2'b00, gate}, 8'h09);
    chk({6'h00, det_n, flt_n}, 8'h03);
    u_host.write_reg(BUS_ADDR_2, 8'h00, 8'h02, ok);
    chk({7'h00, ok}, 8'h00);
    rd_chk(8'h00, 8'h08);
    rd_chk(8'h01, 8'h09);
    complete_run();
  end
endmodule // lnbr_regs_tb
